// *** pkg/fci_pkg.sv ***
// constants and types for the flash command interface host controller
// assumes a 125 MHz clock and a byte-wide asynchronous flash on the pins
// Functional notes
// - after wake, read data is not trusted until the output wakeup time
// - after wake, host waits the write wakeup time before any command
// - block erase needs 20H then D0H, both inside the block
// - byte write is 40H or 10H setup then data, same address
// - write strobe low with chip select low; latched on strobe rising edge
// - host writes only defined command codes
package fci_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  // command codes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_IDENTIFIER   = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
  localparam logic [7:0] CMD_WRITE_ALT    = 8'h10;

  // timing, in ns, and derived clock counts (least times round up)
  localparam int CLK_PERIOD_NS       = 8;
  localparam int WRITE_LOW_NS        = 40;
  localparam int WRITE_RECOVER_NS    = 16;
  localparam int READ_ACCESS_NS      = 100;
  localparam int WAKE_OUT_VALID_NS   = 1000;
  localparam int WAKE_TO_WRITE_NS    = 1000;
  localparam int SYNC_DEPTH          = 3;
  localparam int CNT_W               = 8;

  localparam logic [CNT_W-1:0] WRITE_LOW_CYC =
    CNT_W'((WRITE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WRITE_RECOVER_CYC =
    CNT_W'((WRITE_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] READ_WAIT_CYC =
    CNT_W'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_DEPTH);
  localparam logic [CNT_W-1:0] WAKE_READ_CYC =
    CNT_W'((WAKE_OUT_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_WRITE_CYC =
    CNT_W'((WAKE_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;

  // reset values of pin drivers
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    OP_READ  = 3'b000,
    OP_CMD   = 3'b001,
    OP_DATA  = 3'b010,
    OP_SLEEP = 3'b011,
    OP_WAKE  = 3'b100
  } fci_op_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WR_LOW  = 3'b001,
    ST_WR_REC  = 3'b010,
    ST_RD_WAIT = 3'b011,
    ST_SLEEP   = 3'b100,
    ST_WAKE    = 3'b101
  } fci_state_type;

  typedef enum logic [1:0] {
    MODE_ARRAY  = 2'b00,
    MODE_IDENT  = 2'b01,
    MODE_STATUS = 2'b10
  } fci_mode_type;

endpackage

// *** sim/fci_flash_model.sv ***
// behavioural byte-wide flash answering the host pins
// assumes pins driven by fci_host; program supply level set by the bench
`timescale 1ns/1ps
`default_nettype none
module fci_flash_model #(
  parameter logic [7:0] MAKER_CODE  = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'hC3, // arbitrary value
  parameter int         T_WAKE      = 1000
) (
  input  wire logic        i_power_down_n,
  input  wire logic        i_chip_select_n,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_output_enable_n,
  input  wire logic [19:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_program_supply_high,
  output logic [7:0]       o_dq,
  output logic             o_wake_violation
);
  logic [7:0]  mem [int];
  logic [7:0]  sr, last_q, val, pend;
  logic [19:0] pa;
  logic [1:0]  mode;
  logic        awake, susp;
  int          busy;
  wire logic   en = i_power_down_n && !i_chip_select_n && !i_output_enable_n && awake;
  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction
  initial begin
    sr = 8'h80; mode = 2'b00; pend = 8'h00; busy = 0; susp = 1'b0;
    awake = 1'b0; last_q = 8'h00; o_wake_violation = 1'b0; pa = 20'h0_0000;
  end
  always #50 if (busy > 0 && !susp) busy = busy - 1;
  always @(negedge i_power_down_n) begin
    if (busy > 0) mem[int'(pa)] = 8'hxx;
    busy = 0; susp = 1'b0; pend = 8'h00; awake = 1'b0;
  end
  always @(posedge i_power_down_n) begin
    mode = 2'b00; sr[7:3] = 5'b10000; awake <= #(T_WAKE) 1'b1;
  end
  always @(posedge i_write_strobe_n) if (!i_chip_select_n && i_power_down_n) begin
    if (!awake) o_wake_violation = 1'b1;
    if (pend == 8'h40) begin
      if (i_program_supply_high && i_addr == pa) begin mem[int'(pa)] = rd(pa) & i_dq; busy = 20; end
      else sr[4:3] = {1'b1, !i_program_supply_high};
      pend = 8'h00;
    end else if (pend == 8'h20) begin
      if (i_program_supply_high && i_dq == 8'hD0 && i_addr[19:16] == pa[19:16]) begin
        foreach (mem[k]) if ((k >> 16) == int'(pa[19:16])) mem[k] = 8'hFF;
        busy = 60;
      end else sr[5:3] = {1'b1, 1'b0, !i_program_supply_high};
      pend = 8'h00;
    end else case (i_dq)
      8'hFF: if (busy == 0 || susp) mode = 2'b00;
      8'h90: mode = 2'b01;
      8'h70: mode = 2'b10;
      8'h50: sr[5:3] = 3'b000;
      8'h20, 8'h40, 8'h10: begin
        pend = (i_dq == 8'h20) ? 8'h20 : 8'h40; pa = i_addr; mode = 2'b10;
      end
      8'hB0: if (busy > 0) susp = 1'b1;
      8'hD0: susp = 1'b0;
      default: ;
    endcase
  end
  always @* begin
    case (mode)
      2'b01: val = i_addr[0] ? DEVICE_CODE : MAKER_CODE;
      2'b10: val = {busy == 0 || susp, susp, sr[5:0]};
      default: val = rd(i_addr);
    endcase
  end
  assign o_dq = en ? val : ~last_q;
  always @(en or val) if (en) last_q = val;
endmodule // fci_flash_model
`default_nettype wire

// *** sim/fci_host_asserts.sv ***
// checker for fci_host pin sequencing and handshake timing
// assumes it is bound onto fci_host; one clock domain
`timescale 1ns/1ps
`default_nettype none
module fci_host_asserts (
  input wire logic                i_clk,
  input wire logic                i_arst_n,
  input wire logic                i_req,
  input wire fci_pkg::fci_op_type i_op,
  input wire logic                o_ready,
  input wire logic                o_done,
  input wire logic                o_refused,
  input wire logic                o_asleep,
  input wire logic [1:0]          o_mode,
  input wire logic                o_power_down_n,
  input wire logic                o_chip_select_n,
  input wire logic                o_write_strobe_n,
  input wire logic                o_output_enable_n
);
  logic [7:0] wake_cnt;
  logic [7:0] next_wake_cnt;
  wire logic  take = i_req && o_ready;
  // cycles since the power-down pin last went high
  always_comb begin
    next_wake_cnt = wake_cnt;
    if (!o_power_down_n) next_wake_cnt = 8'h00;
    else if (wake_cnt != 8'hFF) next_wake_cnt = wake_cnt + 8'h01;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) wake_cnt <= 8'h00;
    else wake_cnt <= next_wake_cnt;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence strobe_pulse;
    !o_write_strobe_n [*5] ##1 o_write_strobe_n ##1 o_chip_select_n ##1 (o_done && o_ready);
  endsequence
  sequence sleep_entry;
    (!o_power_down_n && o_chip_select_n && o_output_enable_n) ##1 o_asleep;
  endsequence
  chk_sleep_pin: assert property (o_asleep |-> !o_power_down_n)
    else $error("power-down pin high while asleep");
  chk_sleep_entry: assert property (take && i_op == fci_pkg::OP_SLEEP && !o_asleep |=> sleep_entry)
    else $error("sleep entry sequence wrong");
  chk_pd_quiet: assert property (!o_power_down_n |-> o_chip_select_n)
    else $error("chip selected during power-down");
  chk_strobe_sel: assert property (!o_write_strobe_n |-> !o_chip_select_n && o_output_enable_n)
    else $error("write strobe without chip select");
  chk_strobe_len: assert property ($fell(o_write_strobe_n) |-> strobe_pulse)
    else $error("write pulse shape wrong");
  chk_wake_gap: assert property (!o_chip_select_n |-> wake_cnt >= fci_pkg::WAKE_WRITE_CYC)
    else $error("access too soon after wake");
  chk_wake_mode: assert property (take && i_op == fci_pkg::OP_WAKE && o_asleep
    |=> o_power_down_n ##[120:130] (o_done && o_mode == 2'b00))
    else $error("wake did not finish in array mode");
  chk_refuse_quiet: assert property (o_refused |-> o_write_strobe_n && o_chip_select_n && o_ready)
    else $error("refused request touched pins");
  chk_read_lat: assert property (take && i_op == fci_pkg::OP_READ && !o_asleep
    |=> (!o_output_enable_n && o_write_strobe_n) ##16 (o_done && o_output_enable_n))
    else $error("read cycle timing wrong");
endmodule // fci_host_asserts
bind fci_host fci_host_asserts u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req), .i_op(i_op), .o_ready(o_ready),
  .o_done(o_done), .o_refused(o_refused), .o_asleep(o_asleep), .o_mode(o_mode),
  .o_power_down_n(o_power_down_n), .o_chip_select_n(o_chip_select_n),
  .o_write_strobe_n(o_write_strobe_n), .o_output_enable_n(o_output_enable_n));
`default_nettype wire

// *** sim/fci_host_tb_top.sv ***
// self-checking bench for fci_host against a behavioural flash
// assumes fci_pkg compiled first and the checker bound to fci_host
`timescale 1ns/1ps
`default_nettype none
module fci_host_tb_top;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] DEVID = 8'hC3; // arbitrary value
  logic i_clk, i_arst_n, i_req, vpp, ready, done, refused, asleep, armed;
  logic pd_n, cs_n, we_n, oe_n, dq_oe, viol;
  fci_pkg::fci_op_type i_op;
  logic [19:0] i_addr, f_addr;
  logic [7:0]  i_wdata, rdata, f_dq, h_dq, bus;
  logic [1:0]  mode;
  int          mismatches, comparisons;
  logic [7:0]  exp_mem [int];
  assign bus = dq_oe ? h_dq : f_dq;
  fci_host i_fci_host (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req), .i_op(i_op),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(ready), .o_done(done), .o_refused(refused),
    .o_rdata(rdata), .o_asleep(asleep), .o_write_armed(armed), .o_mode(mode),
    .o_power_down_n(pd_n), .o_chip_select_n(cs_n), .o_write_strobe_n(we_n),
    .o_output_enable_n(oe_n), .o_addr(f_addr), .o_dq(h_dq), .o_dq_oe(dq_oe), .i_dq(bus));
  fci_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID), .T_WAKE(1000)) i_fci_flash_model (
    .i_power_down_n(pd_n), .i_chip_select_n(cs_n), .i_write_strobe_n(we_n),
    .i_output_enable_n(oe_n), .i_addr(f_addr), .i_dq(bus), .i_program_supply_high(vpp),
    .o_dq(f_dq), .o_wake_violation(viol));
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic op(input fci_pkg::fci_op_type o, input logic [19:0] a, input logic [7:0] d,
                    input logic exp_ref);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 400) begin @(posedge i_clk); #1; n++; end
    i_req = 1'b1; i_op = o; i_addr = a; i_wdata = d;
    @(posedge i_clk); #1;
    i_req = 1'b0;
    n = 0;
    while (done !== 1'b1 && refused !== 1'b1 && n < (o == fci_pkg::OP_SLEEP ? 2 : 300)) begin
      @(posedge i_clk); #1; n++;
    end
    if (o != fci_pkg::OP_SLEEP) check({7'h00, exp_ref}, {6'h00, done || refused, refused} - 8'h02);
    if (n == 0) begin @(posedge i_clk); #1; end
  endtask
  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
    op(fci_pkg::OP_READ, a, 8'h00, 1'b0);
    check(exp, rdata);
  endtask
  task automatic wait_ready;
    repeat (100) begin op(fci_pkg::OP_READ, 20'h0_0000, 8'h00, 1'b0); if (rdata[7] === 1'b1) break; end
  endtask
  function automatic logic [7:0] exp_byte(input logic [19:0] a, input logic [7:0] d);
    return (exp_mem.exists(int'(a)) ? exp_mem[int'(a)] : 8'hFF) & d;
  endfunction
  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    #300000;
    mismatches++;
    conclude();
  end
  initial begin
    logic [19:0] a;
    logic [7:0]  d;
    i_arst_n = 1'b0; i_req = 1'b0; i_op = fci_pkg::OP_READ; i_addr = 20'h0_0000;
    i_wdata = 8'h00; vpp = 1'b0;
    mismatches = 0; comparisons = 0;
    void'($urandom(70536));
    repeat (4) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    rd_chk(20'($urandom), 8'hFF);
    check(8'h00, {6'h00, mode});
    op(fci_pkg::OP_CMD, 20'($urandom), 8'h90, 1'b0);
    rd_chk(20'h0_0000, MAKER);
    rd_chk(20'h0_0001, DEVID);
    op(fci_pkg::OP_CMD, 20'h0_0000, 8'h33, 1'b1);
    rd_chk(20'h0_0001, DEVID);
    op(fci_pkg::OP_CMD, 20'h3_0000, 8'h40, 1'b0);
    check(8'h01, {7'h00, armed});
    op(fci_pkg::OP_CMD, 20'h0_0000, 8'hFF, 1'b1);
    op(fci_pkg::OP_DATA, 20'h0_0000, 8'h00, 1'b0);
    check(8'h00, {7'h00, armed});
    op(fci_pkg::OP_DATA, 20'h0_0000, 8'h00, 1'b1);
    op(fci_pkg::OP_CMD, 20'h0_0000, 8'h70, 1'b0);
    rd_chk(20'($urandom), 8'h98);
    op(fci_pkg::OP_CMD, 20'h0_0000, 8'h50, 1'b0);
    rd_chk(20'h0_0000, 8'h80);
    vpp = 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 20'hF_FFFF : 20'($urandom);
      d = (i == 0) ? 8'h00 : 8'($urandom);
      exp_mem[int'(a)] = exp_byte(a, d);
      op(fci_pkg::OP_CMD, a, i[0] ? 8'h10 : 8'h40, 1'b0);
      op(fci_pkg::OP_DATA, a ^ 20'h0_0001, d, 1'b0);
      op(fci_pkg::OP_CMD, 20'h0_0000, 8'hFF, 1'b0);
      rd_chk(20'h0_0000, 8'h00);
      wait_ready;
      op(fci_pkg::OP_CMD, 20'h0_0000, 8'hFF, 1'b0);
      rd_chk(a, exp_mem[int'(a)]);
    end
    op(fci_pkg::OP_CMD, 20'hF_0000, 8'h20, 1'b0);
    op(fci_pkg::OP_CMD, 20'hF_1234, 8'hD0, 1'b0);
    op(fci_pkg::OP_CMD, 20'h0_0000, 8'hB0, 1'b0);
    rd_chk(20'h0_0000, 8'hC0);
    op(fci_pkg::OP_CMD, 20'h0_0000, 8'hD0, 1'b0);
    rd_chk(20'h0_0000, 8'h00);
    wait_ready;
    op(fci_pkg::OP_CMD, 20'h0_0000, 8'hFF, 1'b0);
    rd_chk(20'hF_FFFF, 8'hFF);
    vpp = 1'b0;
    op(fci_pkg::OP_CMD, 20'h1_0000, 8'h40, 1'b0);
    op(fci_pkg::OP_DATA, 20'h0_0000, 8'h55, 1'b0);
    vpp = 1'b1;
    op(fci_pkg::OP_CMD, 20'h1_0000, 8'h40, 1'b0);
    op(fci_pkg::OP_DATA, 20'h0_0000, 8'h55, 1'b0);
    op(fci_pkg::OP_SLEEP, 20'h0_0000, 8'h00, 1'b0);
    check(8'h01, {7'h00, asleep});
    op(fci_pkg::OP_READ, 20'h0_0000, 8'h00, 1'b1);
    op(fci_pkg::OP_WAKE, 20'h0_0000, 8'h00, 1'b0);
    check(8'h00, {6'h00, mode});
    rd_chk(20'h2_0000, 8'hFF);
    op(fci_pkg::OP_CMD, 20'h0_0000, 8'h70, 1'b0);
    rd_chk(20'h0_0000, 8'h80);
    check(8'h00, {7'h00, viol});
    conclude();
  end
endmodule // fci_host_tb_top
`default_nettype wire

// *** verilog/fci_host.sv ***
// host controller driving a byte-wide flash through its command pins
// assumes the user port and the clock share i_clk; flash data pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module fci_host (
  input  wire logic                        i_clk,
  input  wire logic                        i_arst_n,
  input  wire logic                        i_req,
  input  wire fci_pkg::fci_op_type         i_op,
  input  wire logic [fci_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [fci_pkg::DATA_W-1:0]  i_wdata,
  output logic                             o_ready,
  output logic                             o_done,
  output logic                             o_refused,
  output logic [fci_pkg::DATA_W-1:0]       o_rdata,
  output logic                             o_asleep,
  output logic                             o_write_armed,
  output logic [1:0]                       o_mode,
  output logic                             o_power_down_n,
  output logic                             o_chip_select_n,
  output logic                             o_write_strobe_n,
  output logic                             o_output_enable_n,
  output logic [fci_pkg::ADDR_W-1:0]       o_addr,
  output logic [fci_pkg::DATA_W-1:0]       o_dq,
  output logic                             o_dq_oe,
  input  wire logic [fci_pkg::DATA_W-1:0]  i_dq
);

  // three-stage synchroniser per data bit, filtered once stages two and three agree
  logic [fci_pkg::DATA_W-1:0] sync1;
  logic [fci_pkg::DATA_W-1:0] sync2;
  logic [fci_pkg::DATA_W-1:0] sync3;
  logic [fci_pkg::DATA_W-1:0] dq_filt;
  logic [fci_pkg::DATA_W-1:0] next_dq_filt;

  genvar gi;
  generate
    for (gi = 0; gi < fci_pkg::DATA_W; gi++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sync1[gi]   <= 1'b0;
          sync2[gi]   <= 1'b0;
          sync3[gi]   <= 1'b0;
          dq_filt[gi] <= 1'b0;
        end else begin
          sync1[gi]   <= i_dq[gi];
          sync2[gi]   <= sync1[gi];
          sync3[gi]   <= sync2[gi];
          dq_filt[gi] <= next_dq_filt[gi];
        end
      end
      assign next_dq_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : dq_filt[gi];
    end
  endgenerate

  fci_pkg::fci_state_type          state;
  fci_pkg::fci_state_type          next_state;
  logic [fci_pkg::CNT_W-1:0]       cnt;
  logic [fci_pkg::CNT_W-1:0]       next_cnt;
  logic [fci_pkg::ADDR_W-1:0]      setup_addr;
  logic [fci_pkg::ADDR_W-1:0]      next_setup_addr;
  fci_pkg::fci_mode_type           mode;
  fci_pkg::fci_mode_type           next_mode;
  logic                            armed;
  logic                            next_armed;
  logic                            next_ready;
  logic                            next_done;
  logic                            next_refused;
  logic [fci_pkg::DATA_W-1:0]      next_rdata;
  logic                            next_pd_n;
  logic                            next_ce_n;
  logic                            next_we_n;
  logic                            next_oe_n;
  logic [fci_pkg::ADDR_W-1:0]      next_addr;
  logic [fci_pkg::DATA_W-1:0]      next_dq;
  logic                            next_dq_oe;
  logic                            take;
  logic                            code_ok;

  // only defined command codes may reach the pins
  always_comb begin
    case (i_wdata)
      fci_pkg::CMD_READ_ARRAY,
      fci_pkg::CMD_IDENTIFIER,
      fci_pkg::CMD_READ_STATUS,
      fci_pkg::CMD_CLEAR_STATUS,
      fci_pkg::CMD_ERASE_SETUP,
      fci_pkg::CMD_CONFIRM,
      fci_pkg::CMD_SUSPEND,
      fci_pkg::CMD_WRITE_SETUP,
      fci_pkg::CMD_WRITE_ALT: code_ok = 1'b1;
      default:                code_ok = 1'b0;
    endcase
  end

  assign take = o_ready && i_req;

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_setup_addr = setup_addr;
    next_mode       = mode;
    next_armed      = armed;
    next_ready      = 1'b0;
    next_done       = 1'b0;
    next_refused    = 1'b0;
    next_rdata      = o_rdata;
    next_pd_n       = o_power_down_n;
    next_ce_n       = o_chip_select_n;
    next_we_n       = o_write_strobe_n;
    next_oe_n       = o_output_enable_n;
    next_addr       = o_addr;
    next_dq         = o_dq;
    next_dq_oe      = o_dq_oe;
    case (state)
      fci_pkg::ST_IDLE: begin
        next_ready = 1'b1;
        if (take) begin
          next_ready = 1'b0;
          if (i_op == fci_pkg::OP_READ) begin
            next_ce_n  = 1'b0;
            next_oe_n  = 1'b0;
            next_addr  = i_addr;
            next_cnt   = fci_pkg::READ_WAIT_CYC;
            next_state = fci_pkg::ST_RD_WAIT;
          end else if ((i_op == fci_pkg::OP_CMD && code_ok && !armed) ||
                       (i_op == fci_pkg::OP_DATA && armed)) begin
            next_ce_n  = 1'b0;
            next_we_n  = 1'b0;
            next_dq_oe = 1'b1;
            next_dq    = i_wdata;
            next_addr  = (i_op == fci_pkg::OP_DATA) ? setup_addr : i_addr;
            next_cnt   = fci_pkg::WRITE_LOW_CYC;
            next_state = fci_pkg::ST_WR_LOW;
            next_armed = 1'b0;
            if (i_op == fci_pkg::OP_CMD) begin
              if (i_wdata == fci_pkg::CMD_WRITE_SETUP ||
                  i_wdata == fci_pkg::CMD_WRITE_ALT) begin
                next_armed      = 1'b1;
                next_setup_addr = i_addr;
              end
              if (i_wdata == fci_pkg::CMD_READ_ARRAY) begin
                next_mode = fci_pkg::MODE_ARRAY;
              end else if (i_wdata == fci_pkg::CMD_IDENTIFIER) begin
                next_mode = fci_pkg::MODE_IDENT;
              end else if (i_wdata != fci_pkg::CMD_CLEAR_STATUS) begin
                next_mode = fci_pkg::MODE_STATUS;
              end
            end
          end else if (i_op == fci_pkg::OP_SLEEP) begin
            next_pd_n  = 1'b0;
            next_ce_n  = 1'b1;
            next_oe_n  = 1'b1;
            next_armed = 1'b0;
            next_state = fci_pkg::ST_SLEEP;
          end else begin
            next_refused = 1'b1;
            next_ready   = 1'b1;
          end
        end
      end
      fci_pkg::ST_WR_LOW: begin
        next_cnt = cnt - fci_pkg::CNT_ONE;
        if (cnt == fci_pkg::CNT_ONE) begin
          next_we_n  = 1'b1;
          next_cnt   = fci_pkg::WRITE_RECOVER_CYC;
          next_state = fci_pkg::ST_WR_REC;
        end
      end
      fci_pkg::ST_WR_REC: begin
        next_ce_n  = 1'b1;
        next_dq_oe = 1'b0;
        next_cnt   = cnt - fci_pkg::CNT_ONE;
        if (cnt == fci_pkg::CNT_ONE) begin
          next_done  = 1'b1;
          next_ready = 1'b1;
          next_state = fci_pkg::ST_IDLE;
        end
      end
      fci_pkg::ST_RD_WAIT: begin
        next_cnt = cnt - fci_pkg::CNT_ONE;
        if (cnt == fci_pkg::CNT_ONE) begin
          next_rdata = dq_filt;
          next_ce_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_done  = 1'b1;
          next_ready = 1'b1;
          next_state = fci_pkg::ST_IDLE;
        end
      end
      fci_pkg::ST_SLEEP: begin
        next_ready = 1'b1;
        if (take) begin
          if (i_op == fci_pkg::OP_WAKE) begin
            next_ready = 1'b0;
            next_pd_n  = 1'b1;
            next_cnt   = (fci_pkg::WAKE_READ_CYC > fci_pkg::WAKE_WRITE_CYC) ?
                         fci_pkg::WAKE_READ_CYC : fci_pkg::WAKE_WRITE_CYC;
            next_state = fci_pkg::ST_WAKE;
          end else begin
            next_refused = 1'b1;
          end
        end
      end
      fci_pkg::ST_WAKE: begin
        next_pd_n = 1'b1;
        next_cnt  = cnt - fci_pkg::CNT_ONE;
        if (cnt <= fci_pkg::CNT_ONE) begin
          next_cnt   = fci_pkg::CNT_ZERO;
          next_mode  = fci_pkg::MODE_ARRAY;
          next_done  = 1'b1;
          next_ready = 1'b1;
          next_state = fci_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = fci_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state             <= fci_pkg::ST_WAKE;
      cnt               <= (fci_pkg::WAKE_READ_CYC > fci_pkg::WAKE_WRITE_CYC) ?
                           fci_pkg::WAKE_READ_CYC : fci_pkg::WAKE_WRITE_CYC;
      setup_addr        <= fci_pkg::ADDR_RST;
      mode              <= fci_pkg::MODE_ARRAY;
      armed             <= 1'b0;
      o_ready           <= 1'b0;
      o_done            <= 1'b0;
      o_refused         <= 1'b0;
      o_rdata           <= fci_pkg::DATA_RST;
      o_power_down_n    <= 1'b0;
      o_chip_select_n   <= 1'b1;
      o_write_strobe_n  <= 1'b1;
      o_output_enable_n <= 1'b1;
      o_addr            <= fci_pkg::ADDR_RST;
      o_dq              <= fci_pkg::DATA_RST;
      o_dq_oe           <= 1'b0;
    end else begin
      state             <= next_state;
      cnt               <= next_cnt;
      setup_addr        <= next_setup_addr;
      mode              <= next_mode;
      armed             <= next_armed;
      o_ready           <= next_ready;
      o_done            <= next_done;
      o_refused         <= next_refused;
      o_rdata           <= next_rdata;
      o_power_down_n    <= next_pd_n;
      o_chip_select_n   <= next_ce_n;
      o_write_strobe_n  <= next_we_n;
      o_output_enable_n <= next_oe_n;
      o_addr            <= next_addr;
      o_dq              <= next_dq;
      o_dq_oe           <= next_dq_oe;
    end
  end

  // status flags mirrored from state, registered on the same clock edge as state
  logic next_asleep;
  assign next_asleep = (next_state == fci_pkg::ST_SLEEP);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_asleep      <= 1'b0;
      o_write_armed <= 1'b0;
      o_mode        <= 2'b00;
    end else begin
      o_asleep      <= next_asleep;
      o_write_armed <= next_armed;
      o_mode        <= next_mode;
    end
  end

endmodule // fci_host
`default_nettype wire
